// File: bench/perf_mon_ovf_bench.sv
// self-checking bench for the overflow status and freeze logic
`timescale 1ns/10ps
`default_nettype none
module perf_mon_ovf_bench;
   import perf_mon_pkg::*;
   logic                core_clk_i = 1'h0;
   logic                nrst_i, pm_wr_i, pm_rd_i, user_monitor_enable_i, priv_monitor_enable_i;
   logic                retired_i, cpu_normal_i, cpu_lowpower_i, perf_vector_mask_i;
   logic                perf_irq_ack_i, perf_irq_o, freeze_flag_o;
   logic [1:0]          pm_space_i, cpl_i, ms_irq_i;
   reg_idx_t            pm_idx_i;
   logic [STATUS_W-1:0] pm_wdata_i, pm_rdata_o;
   int                  failures = 0;
   int                  check_count = 0;

   perf_mon_ovf i_perf_mon_ovf (
      .core_clk_i            (core_clk_i),
      .nrst_i                (nrst_i),
      .pm_wr_i               (pm_wr_i),
      .pm_rd_i               (pm_rd_i),
      .pm_space_i            (pm_space_i),
      .pm_idx_i              (pm_idx_i),
      .pm_wdata_i            (pm_wdata_i),
      .pm_rdata_o            (pm_rdata_o),
      .user_monitor_enable_i (user_monitor_enable_i),
      .priv_monitor_enable_i (priv_monitor_enable_i),
      .cpl_i                 (cpl_i),
      .retired_i             (retired_i),
      .cpu_normal_i          (cpu_normal_i),
      .cpu_lowpower_i        (cpu_lowpower_i),
      .ms_irq_i              (ms_irq_i),
      .perf_vector_mask_i    (perf_vector_mask_i),
      .perf_irq_ack_i        (perf_irq_ack_i),
      .perf_irq_o            (perf_irq_o),
      .freeze_flag_o         (freeze_flag_o)
   );
   always #12.5 core_clk_i = ~core_clk_i;

   task automatic chk(string what, logic [STATUS_W-1:0] exp, logic [STATUS_W-1:0] got);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic cyc(int n);
      repeat (n) @(negedge core_clk_i);
   endtask : cyc
   // one-cycle strobe; read data registered on the read edge, checked half a cycle later
   task automatic acc(logic w, logic [1:0] sp, reg_idx_t ix, logic [STATUS_W-1:0] d);
      cyc(1);
      pm_wr_i = w;
      pm_rd_i = !w;
      pm_space_i = sp;
      pm_idx_i = ix;
      pm_wdata_i = d;
      cyc(1);
      pm_wr_i = 1'h0;
      pm_rd_i = 1'h0;
   endtask : acc
   task automatic rdc(string what, logic [1:0] sp, reg_idx_t ix, logic [STATUS_W-1:0] exp);
      acc(1'h0, sp, ix, '0);
      chk(what, exp, pm_rdata_o);
   endtask : rdc
   task automatic t_regs;
      for (int i = 0; i < NUM_STATUS; i++) begin
         rdc("status reset", SPACE_STATUS, reg_idx_t'(i), '0);
         acc(1'h1, SPACE_STATUS, reg_idx_t'(i), '1);
         rdc("status ones", SPACE_STATUS, reg_idx_t'(i), IMPL_MASK[i*STATUS_W +: STATUS_W]);
         chk("sw freeze", 64'(i == 0), freeze_flag_o);
         acc(1'h1, SPACE_STATUS, reg_idx_t'(i), '0);
         rdc("status zero", SPACE_STATUS, reg_idx_t'(i), '0);
      end
      acc(1'h1, SPACE_STATUS, 2'h1, '1);
      rdc("word1 ones", SPACE_STATUS, 2'h1, 64'h3);
      rdc("unmapped", 2'h3, 2'h0, '0);
      acc(1'h1, SPACE_STATUS, 2'h1, '0);
      $display("t_regs done");
   endtask : t_regs
   // wrap of an interrupting cycle counter in the low-power state
   task automatic t_wrap;
      acc(1'h1, SPACE_CONFIG, 2'h0, 64'h12f);
      acc(1'h1, SPACE_DATA, 2'h0, 64'hffffffff);
      cpu_lowpower_i = 1'h1;
      cyc(3);
      chk("irq", 64'h1, perf_irq_o);
      rdc("wrap status", SPACE_STATUS, 2'h0, 64'h11);
      rdc("frozen count", SPACE_DATA, 2'h0, '0);
      perf_irq_ack_i = 1'h1;
      cyc(1);
      perf_irq_ack_i = 1'h0;
      chk("ack", '0, perf_irq_o);
      for (int i = 3; i >= 0; i--) acc(1'h1, SPACE_STATUS, reg_idx_t'(i), '0);
      chk("thaw", '0, freeze_flag_o);
      cpu_lowpower_i = 1'h0;
      $display("t_wrap done");
   endtask : t_wrap
   // two silent counters wrap on one retirement
   task automatic t_multi;
      acc(1'h1, SPACE_CONFIG, 2'h1, 64'hf);
      acc(1'h1, SPACE_CONFIG, 2'h2, 64'hf);
      acc(1'h1, SPACE_DATA, 2'h1, 64'hffffffff);
      acc(1'h1, SPACE_DATA, 2'h2, 64'hffffffff);
      retired_i = 1'h1;
      cyc(2);
      retired_i = 1'h0;
      rdc("multi status", SPACE_STATUS, 2'h0, 64'h60);
      rdc("counts on", SPACE_DATA, 2'h1, 64'h1);
      acc(1'h1, SPACE_STATUS, 2'h0, 64'h1);
      retired_i = 1'h1;
      cyc(1);
      retired_i = 1'h0;
      rdc("sw frozen", SPACE_DATA, 2'h2, 64'h1);
      acc(1'h1, SPACE_STATUS, 2'h0, '0);
      $display("t_multi done");
   endtask : t_multi
   // privileged cycle counter gated by its enable and privilege mask
   task automatic t_gate;
      acc(1'h1, SPACE_CONFIG, 2'h3, 64'h141);
      rdc("cfg back", SPACE_CONFIG, 2'h3, 64'h141);
      cpu_normal_i = 1'h1;
      cyc(2);
      rdc("pp off", SPACE_DATA, 2'h3, '0);
      priv_monitor_enable_i = 1'h1;
      cyc(2);
      rdc("normal cycles", SPACE_DATA, 2'h3, 64'h3);
      cpl_i = 2'h1;
      cyc(2);
      rdc("level masked", SPACE_DATA, 2'h3, 64'h4);
      {cpl_i, priv_monitor_enable_i, cpu_normal_i} = '0;
      $display("t_gate done");
   endtask : t_gate
   // masked monitor request racing a zero write, then an unmasked one
   task automatic t_ms;
      cyc(1);
      perf_vector_mask_i = 1'h1;
      pm_wr_i = 1'h1;
      pm_space_i = SPACE_STATUS;
      pm_idx_i = 2'h1;
      pm_wdata_i = '0;
      ms_irq_i = 2'h2;
      cyc(1);
      pm_wr_i = 1'h0;
      ms_irq_i = 2'h0;
      cyc(1);
      chk("ms freeze", 64'h1, freeze_flag_o);
      chk("masked", '0, perf_irq_o);
      perf_vector_mask_i = 1'h0;
      ms_irq_i = 2'h1;
      cyc(1);
      ms_irq_i = 2'h0;
      chk("frozen ms", '0, perf_irq_o);
      rdc("ms status", SPACE_STATUS, 2'h1, 64'h2);
      acc(1'h1, SPACE_STATUS, 2'h0, '0);
      ms_irq_i = 2'h1;
      cyc(1);
      ms_irq_i = 2'h0;
      chk("ms irq", 64'h1, perf_irq_o);
      $display("t_ms done");
   endtask : t_ms
   // switch out with a hardware freeze pending, then switch back and restore
   task automatic t_ctx;
      logic [STATUS_W-1:0] saved [NUM_STATUS];
      for (int i = 0; i < NUM_STATUS; i++) begin
         acc(1'h0, SPACE_STATUS, reg_idx_t'(i), '0);
         saved[i] = pm_rdata_o;
      end
      chk("saved word0", 64'h1, saved[0]);
      chk("saved word1", 64'h3, saved[1]);
      rdc("saved config", SPACE_CONFIG, 2'h0, 64'h12f);
      for (int i = 3; i >= 0; i--) acc(1'h1, SPACE_STATUS, reg_idx_t'(i), '0);
      chk("switched out", '0, freeze_flag_o);
      for (int i = 3; i >= 0; i--) acc(1'h1, SPACE_STATUS, reg_idx_t'(i), saved[i]);
      rdc("restored word1", SPACE_STATUS, 2'h1, 64'h3);
      chk("restored freeze", 64'h1, freeze_flag_o);
      $display("t_ctx done");
   endtask : t_ctx
   task automatic conclude;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : conclude

   // main sequence
   initial begin
      {nrst_i, pm_wr_i, pm_rd_i, user_monitor_enable_i, priv_monitor_enable_i, retired_i,
       cpu_normal_i, cpu_lowpower_i, perf_vector_mask_i, perf_irq_ack_i, pm_space_i, cpl_i,
       ms_irq_i, pm_idx_i, pm_wdata_i} = '0;
      repeat (12) @(posedge core_clk_i);
      cyc(1);
      nrst_i = 1'h1;
      user_monitor_enable_i = 1'h1;
      t_regs;
      t_wrap;
      t_multi;
      t_gate;
      t_ms;
      t_ctx;
      conclude();
   end
   // watchdog, far beyond the roughly 150 cycles the tests need
   initial begin
      repeat (4000) @(posedge core_clk_i);
      failures++;
      conclude();
   end
endmodule : perf_mon_ovf_bench
`default_nettype wire

// File: bench/perf_mon_ovf_properties.sv
// bound checker for the overflow status, freeze and interrupt behaviour
`timescale 1ns/10ps
`default_nettype none
module perf_mon_ovf_properties (
   // clock and reset
   input wire logic                               core_clk_i,
   input wire logic                               nrst_i,
   // register port
   input wire logic                               pm_wr_i,
   input wire logic                               pm_rd_i,
   input wire logic [1:0]                         pm_space_i,
   input wire perf_mon_pkg::reg_idx_t             pm_idx_i,
   input wire logic [perf_mon_pkg::STATUS_W-1:0]  pm_wdata_i,
   input wire logic [perf_mon_pkg::STATUS_W-1:0]  pm_rdata_o,
   // monitors and interrupt
   input wire logic [perf_mon_pkg::NUM_MS-1:0]    ms_irq_i,
   input wire logic                               perf_vector_mask_i,
   input wire logic                               perf_irq_ack_i,
   input wire logic                               perf_irq_o,
   input wire logic                               freeze_flag_o
);
   import perf_mon_pkg::*;
   logic wr0;
   // software access to status word 0
   assign wr0 = pm_wr_i && pm_space_i == SPACE_STATUS && pm_idx_i == 2'h0;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);

   property p_sw_set; wr0 && pm_wdata_i[FREEZE_BIT] |=> freeze_flag_o; endproperty
   a_sw_set: assert property (p_sw_set) else $error("freeze not set by write");
   // a fall right after a reset pulse is the reset, not hardware
   property p_no_self_clr;
      $fell(freeze_flag_o) && $past(nrst_i) |-> $past(wr0) && !$past(pm_wdata_i[FREEZE_BIT]);
   endproperty
   a_no_self_clr: assert property (p_no_self_clr) else $error("freeze fell alone");
   property p_thaw; freeze_flag_o && wr0 && !pm_wdata_i[FREEZE_BIT] |=> !freeze_flag_o; endproperty
   a_thaw: assert property (p_thaw) else $error("freeze not cleared");
   property p_ms_frz; !freeze_flag_o && ms_irq_i != '0 |=> freeze_flag_o; endproperty
   a_ms_frz: assert property (p_ms_frz) else $error("monitor request lost");
   property p_ms_irq;
      !freeze_flag_o && ms_irq_i != '0 && !perf_vector_mask_i |=> perf_irq_o;
   endproperty
   a_ms_irq: assert property (p_ms_irq) else $error("no interrupt pended");
   property p_mask; !perf_irq_o && perf_vector_mask_i |=> !perf_irq_o; endproperty
   a_mask: assert property (p_mask) else $error("masked interrupt pended");
   property p_pend; perf_irq_o && !perf_irq_ack_i |=> perf_irq_o; endproperty
   a_pend: assert property (p_pend) else $error("pending interrupt dropped");
   property p_frozen; freeze_flag_o && !perf_irq_o [*2] |=> !perf_irq_o; endproperty
   a_frozen: assert property (p_frozen) else $error("event while frozen");
   property p_unimpl;
      pm_rd_i && pm_space_i == SPACE_STATUS |=>
         (pm_rdata_o & ~IMPL_MASK[$past(pm_idx_i)*STATUS_W +: STATUS_W]) == '0;
   endproperty
   a_unimpl: assert property (p_unimpl) else $error("unimplemented bit read one");
   property p_rd_frz; pm_rd_i && pm_space_i == SPACE_STATUS && pm_idx_i == 2'h0
      |=> pm_rdata_o[FREEZE_BIT] == $past(freeze_flag_o); endproperty
   a_rd_frz: assert property (p_rd_frz) else $error("freeze readback wrong");
   c_irq: cover property (freeze_flag_o && perf_irq_o);
   c_masked: cover property ($rose(freeze_flag_o) && !perf_irq_o);
   c_ack: cover property (perf_irq_o ##1 !perf_irq_o);
endmodule : perf_mon_ovf_properties
`default_nettype wire
bind perf_mon_ovf perf_mon_ovf_properties i_perf_mon_ovf_properties (.core_clk_i, .nrst_i,
   .pm_wr_i, .pm_rd_i, .pm_space_i, .pm_idx_i, .pm_wdata_i, .pm_rdata_o, .ms_irq_i,
   .perf_vector_mask_i, .perf_irq_ack_i, .perf_irq_o, .freeze_flag_o);

// File: rtl/perf_cnt_if.sv
// bundle between the freeze control and the generic counters
`timescale 1ns/10ps
`default_nettype none
interface perf_cnt_if;
   import perf_mon_pkg::*;

   // shared enables and events
   logic                 frozen;
   logic                 up_en;
   logic                 pp_en;
   logic [1:0]           cpl;
   logic                 retire_evt;
   logic                 cycle_evt;
   logic [STATUS_W-1:0]  wdata;
   // per counter strobes and results
   logic                 cfg_we [NUM_CNT];
   logic                 dat_we [NUM_CNT];
   logic                 wrap   [NUM_CNT];
   cnt_cfg_s             cfg    [NUM_CNT];
   logic [COUNT_W-1:0]   count  [NUM_CNT];

   modport ctrl (output frozen, up_en, pp_en, cpl, retire_evt, cycle_evt, wdata,
                 output cfg_we, dat_we, input wrap, cfg, count);
   modport cnt  (input frozen, up_en, pp_en, cpl, retire_evt, cycle_evt, wdata,
                 input cfg_we, dat_we, output wrap, cfg, count);
endinterface : perf_cnt_if
`default_nettype wire

// File: rtl/perf_counter.sv
// one generic counter pair: configuration, gated counting, wrap detection
`timescale 1ns/10ps
`default_nettype none
module perf_counter #(
   parameter int IDX = 0
) (
   // clock and reset
   input  wire logic  core_clk_i,
   input  wire logic  nrst_i,
   // link to the freeze control
   perf_cnt_if.cnt    cif
);
   import perf_mon_pkg::*;

   typedef struct packed {
      cnt_cfg_s           cfg;
      logic [COUNT_W-1:0] count;
   } cnt_state_s;

   cnt_state_s st_ff;
   cnt_state_s nxt_st;
   logic       run;
   logic       hit;

   // enable, event select and next state
   always_comb begin
      nxt_st = st_ff;
      run = !cif.frozen && st_ff.cfg.plm[cif.cpl]
            && (st_ff.cfg.pm ? cif.pp_en : cif.up_en); // see RULE18 see RULE4
      hit = run && ((st_ff.cfg.evt == EVT_CYCLES) ? cif.cycle_evt : cif.retire_evt);
      if (hit) begin
         nxt_st.count = st_ff.count + COUNT_W'(1); // wraps to zero, keeps counting see RULE19
      end
      // a software load wins over the increment of the same cycle
      if (cif.dat_we[IDX]) begin
         nxt_st.count = cif.wdata[COUNT_W-1:0];
      end
      if (cif.cfg_we[IDX]) begin
         nxt_st.cfg.plm = cif.wdata[CFG_PLM_MSB:CFG_PLM_LSB];
         nxt_st.cfg.oi  = cif.wdata[CFG_OI_BIT];
         nxt_st.cfg.pm  = cif.wdata[CFG_PM_BIT];
         nxt_st.cfg.evt = cif.wdata[CFG_EVT_BIT];
      end
   end

   // state register
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         st_ff <= '{cfg: CFG_RST, count: COUNT_RST};
      end else begin
         st_ff <= nxt_st;
      end
   end

   // results back to the control
   assign cif.wrap[IDX]  = hit && (st_ff.count == '1);
   assign cif.cfg[IDX]   = st_ff.cfg;
   assign cif.count[IDX] = st_ff.count;

endmodule : perf_counter
`default_nettype wire

// File: rtl/perf_mon_ovf.sv
// overflow status registers, freeze bit and monitor interrupt of the perf monitor
// What this block and the software using it do
// RULE1: wrap of a counter with overflow_irq_enable set sets freeze_flag, bit 0.
// RULE2: a model-specific monitor interrupt request also sets freeze_flag.
// RULE3: software may write freeze_flag to one or zero.
// RULE4: freeze_flag one stops all counting; zero lets other enables decide.
// RULE5: each implemented counter has a sticky status bit set on its overflow.
// RULE6: simultaneous overflows set all their status bits in the same cycle.
// RULE7: hardware never clears status or freeze bits; only software zero writes.
// RULE8: unimplemented status positions read zero and ignore writes.
// RULE9: an event counts retired instructions, nops and predicated-off included.
// RULE10: an event counts clock cycles in the normal or low-power state.
// RULE11: interrupting overflow or monitor request sets status, interrupt, freeze.
// RULE12: once frozen, counting stays off until software clears freeze_flag.
// RULE13: handler numbers counters 64*register+bit, scanning register 0 from bit 4.
// RULE14: handler clears registers 3, 2, 1 and register 0 last.
// RULE15: software ignores an interrupt with freeze clear or both enables off.
// RULE16: context switch saves status registers before masked config and data.
// RULE17: returning to a frozen context, software replays the monitor interrupt.
// RULE18: a counter runs if unfrozen, level permitted and selected enable set.
// RULE19: wrap without overflow_irq_enable sets status only; counting continues.
// RULE20: perf_vector_mask one blocks pending; zero holds the interrupt pending.
// RULE21: a hardware set in the same cycle as a software write wins.
`timescale 1ns/10ps
`default_nettype none
module perf_mon_ovf (
   // clock and reset
   input  wire logic                           core_clk_i,
   input  wire logic                           nrst_i,
   // monitor register access
   input  wire logic                           pm_wr_i,
   input  wire logic                           pm_rd_i,
   input  wire logic [1:0]                     pm_space_i,
   input  wire perf_mon_pkg::reg_idx_t         pm_idx_i,
   input  wire logic [perf_mon_pkg::STATUS_W-1:0] pm_wdata_i,
   // read answer
   output logic [perf_mon_pkg::STATUS_W-1:0]   pm_rdata_o,
   // processor status
   input  wire logic                           user_monitor_enable_i,
   input  wire logic                           priv_monitor_enable_i,
   input  wire logic [1:0]                     cpl_i,
   // events
   input  wire logic                           retired_i,
   input  wire logic                           cpu_normal_i,
   input  wire logic                           cpu_lowpower_i,
   // model-specific monitor requests
   input  wire logic [perf_mon_pkg::NUM_MS-1:0] ms_irq_i,
   // interrupt
   input  wire logic                           perf_vector_mask_i,
   input  wire logic                           perf_irq_ack_i,
   // interrupt and freeze state
   output logic                                perf_irq_o,
   output logic                                freeze_flag_o
);
   import perf_mon_pkg::*;

   // every bit of state of this module, registered in one place
   typedef struct packed {
      logic [STATUS_ALL-1:0] status;   // four 64-bit words, word 0 lowest
      logic                  pend;
      logic [STATUS_W-1:0]   rdata;
   } ovf_state_s;

   ovf_state_s            st_ff;
   ovf_state_s            nxt_st;
   // combinational helpers, none of them holds state
   logic [STATUS_ALL-1:0] hw_set;
   logic                  frz_req;
   logic [NUM_MS-1:0]     ms_live;
   logic                  wr_status;

   // one bundle carries the enables down and the wrap results back up
   perf_cnt_if cif ();

   // shared enables toward the counters; the freeze stops every slot
   // from the edge that set it, so nothing counts past a frozen wrap
   assign cif.frozen     = st_ff.status[FREEZE_BIT]; // see RULE4 see RULE12
   assign cif.up_en      = user_monitor_enable_i;
   assign cif.pp_en      = priv_monitor_enable_i;
   assign cif.cpl        = cpl_i;
   assign cif.retire_evt = retired_i;                        // see RULE9
   assign cif.cycle_evt  = cpu_normal_i || cpu_lowpower_i;   // see RULE10
   assign cif.wdata      = pm_wdata_i;

   // per counter write strobes and the counters themselves
   for (genvar g = 0; g < NUM_CNT; g++) begin : g_cnt
      // slot g owns status bit FIRST_CNT + g
      assign cif.cfg_we[g] = pm_wr_i && (pm_space_i == SPACE_CONFIG)
                             && (pm_idx_i == reg_idx_t'(g));
      assign cif.dat_we[g] = pm_wr_i && (pm_space_i == SPACE_DATA)
                             && (pm_idx_i == reg_idx_t'(g));
      // one counter per slot, all sharing the bundle
      perf_counter #(
         .IDX        (g)
      ) u_cnt (
         .core_clk_i (core_clk_i),
         .nrst_i     (nrst_i),
         .cif        (cif)
      );
   end

   // a status write, whichever word it addresses
   assign wr_status = pm_wr_i && (pm_space_i == SPACE_STATUS);

   // model-specific monitors are frozen with everything else, so a
   // request arriving while frozen leaves no stale status bit behind
   assign ms_live = cif.frozen ? '0 : ms_irq_i; // see RULE4

   // hardware set vector and freeze request
   always_comb begin
      hw_set  = '0;
      frz_req = 1'b0;

      // generic pairs: every wrap is recorded, only enabled pairs freeze
      for (int i = 0; i < NUM_CNT; i++) begin
         if (cif.wrap[i]) begin
            hw_set[FIRST_CNT + i] = 1'b1;      // every wrap of the cycle see RULE5 see RULE6
            if (cif.cfg[i].oi) begin
               frz_req = 1'b1;                 // see RULE1 see RULE19
            end
         end
      end

      // model-specific monitors have no enable: each live request freezes, and interrupts unless masked
      for (int k = 0; k < NUM_MS; k++) begin
         if (ms_live[k]) begin
            hw_set[MS_BASE + k] = 1'b1;
            frz_req             = 1'b1;        // see RULE2
         end
      end

      // any freeze request also sets the freeze bit itself
      if (frz_req) begin
         hw_set[FREEZE_BIT] = 1'b1;            // see RULE11
      end
   end

   // next state: software write first, hardware sets layered on top
   always_comb begin
      // hold everything unless a branch below says otherwise
      nxt_st = st_ff;
      if (wr_status) begin
         // software may set or clear freeze and overflow bits see RULE3 see RULE7
         // only the addressed word changes; masked positions stay zero
         for (int w = 0; w < NUM_STATUS; w++) begin
            if (pm_idx_i == reg_idx_t'(w)) begin
               nxt_st.status[w*STATUS_W +: STATUS_W] =
                  pm_wdata_i & IMPL_MASK[w*STATUS_W +: STATUS_W]; // see RULE8
            end
         end
      end
      // hardware only ever sets, and wins over a clearing write see RULE21 see RULE7
      nxt_st.status = nxt_st.status | (hw_set & IMPL_MASK);

      // pending interrupt, held until acknowledged unless masked; a request
      // in the acknowledge cycle must not be lost, so the set is tested first
      if (frz_req && !perf_vector_mask_i) begin
         nxt_st.pend = 1'b1;                   // see RULE20 see RULE11
      end else if (perf_irq_ack_i) begin
         nxt_st.pend = 1'b0;
      end

      // read answer is registered, one cycle after the strobe
      // a read sees the value before any write of the same edge
      if (pm_rd_i) begin
         unique case (pm_space_i)
            // status flops never hold unimplemented ones, so copy whole words
            SPACE_STATUS: begin
               nxt_st.rdata = '0;
               for (int r = 0; r < NUM_STATUS; r++) begin
                  if (pm_idx_i == reg_idx_t'(r)) begin
                     nxt_st.rdata = st_ff.status[r*STATUS_W +: STATUS_W]; // see RULE8
                  end
               end
            end
            // configuration fields packed back into their positions
            SPACE_CONFIG: begin
               nxt_st.rdata = '0;
               for (int c = 0; c < NUM_CNT; c++) begin
                  if (pm_idx_i == reg_idx_t'(c)) begin
                     nxt_st.rdata[CFG_PLM_MSB:CFG_PLM_LSB] = cif.cfg[c].plm;
                     nxt_st.rdata[CFG_OI_BIT]  = cif.cfg[c].oi;
                     nxt_st.rdata[CFG_PM_BIT]  = cif.cfg[c].pm;
                     nxt_st.rdata[CFG_EVT_BIT] = cif.cfg[c].evt;
                  end
               end
            end
            // counter data in the low half, upper half zero
            SPACE_DATA: begin
               nxt_st.rdata = '0;
               for (int d = 0; d < NUM_CNT; d++) begin
                  if (pm_idx_i == reg_idx_t'(d)) begin
                     nxt_st.rdata[COUNT_W-1:0] = cif.count[d];
                  end
               end
            end
            default: begin
               nxt_st.rdata = '0;              // unmapped space reads zero
            end
         endcase
      end
   end

   // state register; reset is synchronous, like the rest of the core
   // reset clears freeze as well; counters stay idle until configured
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         st_ff <= '{status: STATUS_RST, pend: 1'b0, rdata: RDATA_RST};
      end else begin
         st_ff <= nxt_st;
      end
   end

   // outputs straight from flops
   // freeze_flag_o mirrors bit 0 of word 0, the same flop software reads
   assign pm_rdata_o    = st_ff.rdata;
   assign perf_irq_o    = st_ff.pend;
   assign freeze_flag_o = st_ff.status[FREEZE_BIT];

endmodule : perf_mon_ovf
`default_nettype wire

// File: rtl/perf_mon_pkg.sv
// constants, field layouts and types for the overflow status and freeze logic
package perf_mon_pkg;

   // status register file geometry
   localparam int NUM_STATUS = 4;
   localparam int STATUS_W   = 64;
   localparam int STATUS_ALL = NUM_STATUS * STATUS_W;

   // status bit positions
   localparam int FREEZE_BIT = 0;
   localparam int IGN_LSB    = 1;
   localparam int IGN_MSB    = 3;
   localparam int FIRST_CNT  = 4;   // first generic pair owning an overflow bit
   localparam int MS_BASE    = 64;  // model-specific monitor bits start here

   // implemented monitors
   localparam int NUM_CNT = 4;      // generic pairs 4..7
   localparam int NUM_MS  = 2;      // model-specific monitors at bits 64, 65
   localparam int COUNT_W = 32;

   // writable / readable status positions; the rest read zero and ignore writes
   localparam logic [STATUS_ALL-1:0] IMPL_MASK =
      {128'h0, 64'h0000000000000003, 64'h00000000000000f1};

   // access spaces on the register port
   localparam logic [1:0] SPACE_STATUS = 2'h0;
   localparam logic [1:0] SPACE_CONFIG = 2'h1;
   localparam logic [1:0] SPACE_DATA   = 2'h2;

   // counter configuration word layout
   localparam int CFG_PLM_LSB = 0;
   localparam int CFG_PLM_MSB = 3;
   localparam int CFG_OI_BIT  = 5;
   localparam int CFG_PM_BIT  = 6;
   localparam int CFG_EVT_BIT = 8;

   // event selection codes
   localparam logic EVT_RETIRED = 1'h0;
   localparam logic EVT_CYCLES  = 1'h1;

   // values after reset
   localparam logic [STATUS_ALL-1:0] STATUS_RST = '0;
   localparam logic [COUNT_W-1:0]    COUNT_RST  = '0;
   localparam logic [STATUS_W-1:0]   RDATA_RST  = '0;

   typedef logic [1:0] reg_idx_t;

   typedef struct packed {
      logic [3:0] plm;    // privilege levels allowed to count
      logic       oi;     // interrupt and freeze on wrap
      logic       pm;     // privileged monitor
      logic       evt;    // event selection
   } cnt_cfg_s;

   localparam cnt_cfg_s CFG_RST = '0;

endpackage : perf_mon_pkg
